// File: design/tpo_pkg.sv
package tpo_pkg;
  // Register word offsets (byte addresses, one aligned word each)
  localparam logic [3:0] TPO_OFS_CONFIG = 4'h0;
  localparam logic [3:0] TPO_OFS_CNT_LO = 4'h4;
  localparam logic [3:0] TPO_OFS_CNT_HI = 4'h8;
  localparam logic [3:0] TPO_OFS_IRQ = 4'hc;
  // Config field positions
  localparam int TPO_CFG_RUN = 7;
  localparam int TPO_CFG_BYTE = 6;
  localparam int TPO_CFG_CSEL = 5;
  localparam int TPO_CFG_EDGE = 4;
  localparam int TPO_CFG_BYP = 3;
  localparam int TPO_CFG_PS_LSB = 0;
  // Irq register field positions
  localparam int TPO_IRQ_EN = 5;
  localparam int TPO_IRQ_FLAG = 2;
  // Reset values and prescaler step
  localparam logic [7:0] TPO_CONFIG_RST = 8'hff;
  localparam logic [7:0] TPO_BYTE_RST = 8'h00;
  localparam logic [7:0] TPO_PS_ZERO = 8'h00;
  localparam logic [7:0] TPO_PS_ONE = 8'h01;
  // Rollover points and count step
  localparam logic [7:0] TPO_BYTE_MAX = 8'hff;
  localparam logic [15:0] TPO_FULL_MAX = 16'hffff;
  localparam logic [15:0] TPO_CNT_STEP = 16'h0001;
  // Read data padding above the byte lane, and the idle read word
  localparam logic [23:0] TPO_RD_PAD = 24'h00_0000;
  localparam logic [31:0] TPO_RD_ZERO = 32'h0000_0000;
endpackage : tpo_pkg

// File: design/tpo_timer.sv
`timescale 1ns/1ns
`default_nettype none
module tpo_timer
  import tpo_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sleep_i,
  input wire logic ext_clk_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o
);

  logic [7:0] config_q;
  logic [7:0] count_lo_q;
  logic [7:0] count_hi_q;
  logic [7:0] prescale_q;
  logic overflow_flag_q;
  logic overflow_irq_en_q;
  logic [7:0] irq_other_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic ext_s1_q;
  logic ext_s2_q;
  logic ext_s3_q;

  // Bus decode; single-cycle answer, ack dropped the cycle after
  logic req;
  logic wr;
  logic wr_lane0;
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  assign wr = req && wb_we_i;
  assign wr_lane0 = wr && wb_sel_i[0];
  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdata_q;

  logic wr_cfg;
  logic wr_lo;
  logic wr_hi;
  logic wr_irq;
  assign wr_cfg = wr_lane0 && (wb_adr_i == TPO_OFS_CONFIG);
  assign wr_lo = wr_lane0 && (wb_adr_i == TPO_OFS_CNT_LO);
  assign wr_hi = wr_lane0 && (wb_adr_i == TPO_OFS_CNT_HI);
  assign wr_irq = wr_lane0 && (wb_adr_i == TPO_OFS_IRQ);

  // Field aliases
  logic run_en;
  logic byte_width_sel;
  logic count_clock_sel;
  logic count_edge_sel;
  logic prescaler_bypass_sel;
  logic [2:0] prescale_ratio_sel;
  assign run_en = config_q[TPO_CFG_RUN];
  assign byte_width_sel = config_q[TPO_CFG_BYTE];
  assign count_clock_sel = config_q[TPO_CFG_CSEL];
  assign count_edge_sel = config_q[TPO_CFG_EDGE];
  assign prescaler_bypass_sel = config_q[TPO_CFG_BYP];
  assign prescale_ratio_sel = config_q[TPO_CFG_PS_LSB +: 3];

  // External count pin passes two flops before any logic reads it; the pin is
  // asynchronous, so the first flop may go metastable and only the second reads it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_s1_q <= 1'b0;
      ext_s2_q <= 1'b0;
    end else begin
      ext_s1_q <= ext_clk_i;
      ext_s2_q <= ext_s1_q;
    end
  end

  // Edge history: third flop holds the previous synchronised level; it resets to
  // the pin's idle low level, so a quiet pin gives no false edge after reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_s3_q <= 1'b0;
    end else begin
      ext_s3_q <= ext_s2_q;
    end
  end

  // Count clock tick: internal clock every cycle, or chosen pin edge
  logic ext_edge;
  logic src_tick;
  assign ext_edge = count_edge_sel ? (ext_s3_q && !ext_s2_q) : (!ext_s3_q && ext_s2_q);
  assign src_tick = run_en && !sleep_i && (count_clock_sel ? ext_edge : 1'b1);

  // Prescaler output: bit n toggling high-to-low marks 2^(n+1) ticks
  logic [7:0] prescale_d;
  logic ps_tick;
  logic timer_tick;
  assign prescale_d = prescale_q + TPO_PS_ONE;
  assign ps_tick = prescale_q[prescale_ratio_sel] && !prescale_d[prescale_ratio_sel];
  // Bypass select; may change on the fly
  assign timer_tick = src_tick && (prescaler_bypass_sel ? 1'b1 : ps_tick);

  logic cnt_write;
  assign cnt_write = wr_lo || wr_hi;

  // Hidden eight-bit prescaler; no bus path to it
  // It only runs while assigned, so a later switch back to the prescaler starts
  // from wherever it stood when bypass was set, as count writes in bypass do not clear it
  logic [7:0] prescale_next;
  always_comb begin
    prescale_next = prescale_q;
    if (cnt_write && !prescaler_bypass_sel) begin
      prescale_next = TPO_PS_ZERO;
    end else if (src_tick && !prescaler_bypass_sel) begin
      prescale_next = prescale_d;
    end
  end

  // Prescaler register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prescale_q <= TPO_PS_ZERO;
    end else begin
      prescale_q <= prescale_next;
    end
  end

  // Configuration; only its own address writes it, so count writes keep the bypass bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      config_q <= TPO_CONFIG_RST;
    end else if (wr_cfg) begin
      config_q <= wb_dat_i[7:0];
    end
  end

  // Rollover compare per width; the width select only narrows the compare and the
  // high byte carry, so switching widths mid-count never corrupts the low byte
  logic [15:0] count_full;
  logic [15:0] count_inc;
  logic lo_at_max;
  logic full_at_max;
  logic ovf_event;
  assign count_full = {count_hi_q, count_lo_q};
  assign count_inc = count_full + TPO_CNT_STEP;
  assign lo_at_max = (count_lo_q == TPO_BYTE_MAX);
  assign full_at_max = (count_full == TPO_FULL_MAX);
  // Rollover detect per width
  // A count write in the same cycle swallows the tick, so the lost step sets no flag
  assign ovf_event = timer_tick && !cnt_write && (byte_width_sel ? lo_at_max : full_at_max);

  // Next low byte: bus write wins over an increment in the same cycle
  logic [7:0] count_lo_d;
  always_comb begin
    count_lo_d = count_lo_q;
    if (wr_lo) begin
      count_lo_d = wb_dat_i[7:0];
    end else if (timer_tick && !cnt_write) begin
      count_lo_d = count_inc[7:0];
    end
  end

  // Next high byte: holds still in eight-bit mode, where it is plain storage
  // that software may preload before switching to sixteen-bit counting
  logic [7:0] count_hi_d;
  always_comb begin
    count_hi_d = count_hi_q;
    if (wr_hi) begin
      count_hi_d = wb_dat_i[7:0];
    end else if (timer_tick && !cnt_write && !byte_width_sel) begin
      count_hi_d = count_inc[15:8];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_lo_q <= TPO_BYTE_RST;
    end else begin
      count_lo_q <= count_lo_d;
    end
  end

  // High byte register; there is no shadow latch, so software that
  // reads both bytes while counting can see a torn value across a carry
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_hi_q <= TPO_BYTE_RST;
    end else begin
      count_hi_q <= count_hi_d;
    end
  end

  // Sticky flag; write one clears, a new overflow beats the clear
  logic flag_clr;
  assign flag_clr = wr_irq && wb_dat_i[TPO_IRQ_FLAG];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_flag_q <= 1'b0;
    end else if (ovf_event) begin
      overflow_flag_q <= 1'b1;
    end else if (flag_clr) begin
      overflow_flag_q <= 1'b0;
    end
  end

  // Interrupt enable, written only through the irq register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      overflow_irq_en_q <= 1'b0;
    end else if (wr_irq) begin
      overflow_irq_en_q <= wb_dat_i[TPO_IRQ_EN];
    end
  end

  // Remaining irq register bits are plain storage with no function in this block
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_other_q <= TPO_BYTE_RST;
    end else if (wr_irq) begin
      irq_other_q <= wb_dat_i[7:0];
    end
  end

  // Enable gates the request; software clears the flag
  // The level stays up until the flag or the enable is cleared, so an
  // unserviced overflow is never lost
  assign irq_o = overflow_flag_q && overflow_irq_en_q;

  // Read view of the irq register: live flag and enable over the stored bits
  logic [7:0] irq_rd;
  always_comb begin
    irq_rd = irq_other_q;
    irq_rd[TPO_IRQ_EN] = overflow_irq_en_q;
    irq_rd[TPO_IRQ_FLAG] = overflow_flag_q;
  end

  // Read byte select; unmapped addresses read zero and still ack, so a
  // stray access never stalls the bus
  logic [7:0] rd_byte;
  always_comb begin
    rd_byte = TPO_BYTE_RST;
    unique case (wb_adr_i)
      TPO_OFS_CONFIG: rd_byte = config_q;
      TPO_OFS_CNT_LO: rd_byte = count_lo_q;
      TPO_OFS_CNT_HI: rd_byte = count_hi_q;
      TPO_OFS_IRQ: rd_byte = irq_rd;
      default: rd_byte = TPO_BYTE_RST;
    endcase
  end

  // Next read word, loaded only when a read is taken
  logic [31:0] rdata_d;
  always_comb begin
    rdata_d = rdata_q;
    if (req && !wb_we_i) begin
      rdata_d = {TPO_RD_PAD, rd_byte};
    end
  end

  // Ack is a one-cycle pulse; req is blocked while ack is high, so a request
  // still held in the answer cycle is not taken twice
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end

  // Read data holds until the next read, so a master that samples ack late
  // still sees the word it asked for
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_q <= TPO_RD_ZERO;
    end else begin
      rdata_q <= rdata_d;
    end
  end

endmodule : tpo_timer
`default_nettype wire

// File: verification/tpo_checker.sv
`timescale 1ns/1ns
`default_nettype none
module tpo_checker
  import tpo_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic sleep_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic irq_o
);
  logic rd_irq_q;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Marks a read of the flag register, so its answer can be tied to the level
  always_ff @(posedge clk_i) begin
    if (rst_i) rd_irq_q <= 1'b0;
    else rd_irq_q <= wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && wb_adr_i == TPO_OFS_IRQ;
  end
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_on_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("request not answered");
  a_ack_has_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_read_byte: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
    else $error("upper read bits set");
  a_unmapped_zero: assert property (wb_ack_o && $past(!wb_we_i && wb_adr_i[1:0] != 2'h0)
    |-> wb_dat_o == 32'h0) else $error("unmapped read nonzero");
  // Only the flag can change between the read edge and the answer
  a_irq_needs_en: assert property (wb_ack_o && rd_irq_q && irq_o |-> wb_dat_o[TPO_IRQ_EN])
    else $error("irq with enable clear");
  a_irq_when_set: assert property (wb_ack_o && rd_irq_q && wb_dat_o[TPO_IRQ_EN]
    && wb_dat_o[TPO_IRQ_FLAG] |-> irq_o) else $error("irq low while pending");
  // No ticks in sleep, so only a register write may raise the level
  a_sleep_no_irq: assert property ($rose(irq_o) |-> wb_ack_o || !$past(sleep_i)
    || !$past(sleep_i, 2) || !$past(sleep_i, 3)) else $error("irq rose in sleep");
  a_reset_quiet: assert property (disable iff (1'b0) $fell(rst_i) |-> !wb_ack_o && !irq_o)
    else $error("outputs busy after reset");
  c_write: cover property (wb_ack_o && $past(wb_we_i));
  c_irq_up: cover property ($rose(irq_o));
  c_irq_down: cover property ($fell(irq_o));
endmodule : tpo_checker
bind tpo_timer tpo_checker u_chk (.clk_i, .rst_i, .sleep_i, .wb_adr_i, .wb_we_i, .wb_cyc_i,
  .wb_stb_i, .wb_dat_o, .wb_ack_o, .irq_o);
`default_nettype wire

// File: verification/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
  import tpo_pkg::*;
;
  logic clk_i = 0, rst_i = 1, sleep_i = 1, we = 0, cyc = 0, stb = 0, ack, irq;
  logic ext = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, rd;
  int err_count = 0, compares = 0, cyc_n = 0;
  tpo_timer dut (.clk_i, .rst_i, .sleep_i, .ext_clk_i(ext), .wb_adr_i(adr), .wb_dat_i(wdat),
    .wb_we_i(we), .wb_sel_i(4'hf), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
    .wb_ack_o(ack), .irq_o(irq));
  initial forever #5 clk_i = ~clk_i;
  // Hang guard, far above the few thousand cycles the tests need
  always @(posedge clk_i) begin
    cyc_n++;
    if (cyc_n == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // One classic cycle; no latency assumed, the guard ends a lost ack
  task automatic bus(input logic [3:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_i);
    adr <= a;
    we <= w;
    wdat <= {24'h0, d};
    cyc <= 1'b1;
    stb <= 1'b1;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : bus
  task automatic rdc(input logic [3:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    chk(rd, {24'h0, e});
  endtask : rdc
  // Sleep gates every tick, so k cycles awake give exactly k count clocks
  task automatic ticks(input int k);
    @(posedge clk_i);
    sleep_i <= 1'b0;
    repeat (k) @(posedge clk_i);
    sleep_i <= 1'b1;
  endtask : ticks
  task automatic t_eight();
    rdc(TPO_OFS_CONFIG, TPO_CONFIG_RST);
    rdc(TPO_OFS_IRQ, 8'h00);
    rdc(4'h2, 8'h00);
    bus(TPO_OFS_CONFIG, 1'b1, 8'hc8);
    bus(TPO_OFS_CNT_LO, 1'b1, 8'hfe);
    ticks(3);
    rdc(TPO_OFS_CNT_LO, 8'h01);
    rdc(TPO_OFS_IRQ, 8'h04);
    chk(irq, 0);
    bus(TPO_OFS_IRQ, 1'b1, 8'h20);
    chk(irq, 1);
    bus(TPO_OFS_IRQ, 1'b1, 8'h24);
    chk(irq, 0);
    $display("eight-bit test done");
  endtask : t_eight
  task automatic t_sixteen();
    bus(TPO_OFS_CONFIG, 1'b1, 8'h88);
    bus(TPO_OFS_CNT_HI, 1'b1, 8'hff);
    bus(TPO_OFS_CNT_LO, 1'b1, 8'hfe);
    ticks(1);
    rdc(TPO_OFS_IRQ, 8'h20);
    ticks(1);
    rdc(TPO_OFS_CNT_HI, 8'h00);
    rdc(TPO_OFS_IRQ, 8'h24);
    bus(TPO_OFS_IRQ, 1'b1, 8'h04);
    chk(irq, 0);
    $display("sixteen-bit test done");
  endtask : t_sixteen
  // A missed clear on the second write would give one count too many
  task automatic t_prescale();
    int d;
    for (int n = 0; n < 8; n++) begin
      d = 2 << n;
      bus(TPO_OFS_CONFIG, 1'b1, 8'h80 | n[7:0]);
      bus(TPO_OFS_CNT_LO, 1'b1, 8'h00);
      bus(TPO_OFS_CNT_HI, 1'b1, 8'h00);
      ticks(d - 1);
      bus(TPO_OFS_CNT_HI, 1'b1, 8'h00);
      ticks(3 * d - 1);
      rdc(TPO_OFS_CNT_LO, 8'h02);
      rdc(TPO_OFS_CONFIG, 8'h80 | n[7:0]);
    end
    bus(TPO_OFS_CONFIG, 1'b1, 8'h88);
    ticks(2);
    rdc(TPO_OFS_CNT_LO, 8'h04);
    $display("prescaler test done");
  endtask : t_prescale
  // Pin as count clock, rising then falling edge; three pulses count three each
  task automatic t_ext();
    bus(TPO_OFS_CNT_LO, 1'b1, 8'h00);
    for (int m = 0; m < 2; m++) begin
      bus(TPO_OFS_CONFIG, 1'b1, (m == 0) ? 8'he8 : 8'hf8);
      @(posedge clk_i);
      sleep_i <= 1'b0;
      repeat (3) begin
        ext <= 1'b1;
        repeat (4) @(posedge clk_i);
        ext <= 1'b0;
        repeat (4) @(posedge clk_i);
      end
      sleep_i <= 1'b1;
      rdc(TPO_OFS_CNT_LO, (m == 0) ? 8'h03 : 8'h06);
    end
    $display("pin clock test done");
  endtask : t_ext
  // Reset in mid-run brings config, low count and irq registers back to their reset values
  task automatic t_reset();
    bus(TPO_OFS_IRQ, 1'b1, 8'h20);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(TPO_OFS_CONFIG, TPO_CONFIG_RST);
    rdc(TPO_OFS_CNT_LO, 8'h00);
    rdc(TPO_OFS_IRQ, 8'h00);
    chk(irq, 0);
    $display("reset test done");
  endtask : t_reset
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    t_eight();
    t_sixteen();
    t_prescale();
    t_ext();
    t_reset();
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
